/* rtc_timer_pkg.sv */
// shared constants, field positions and carrier types for the rtc timer
package rtc_timer_pkg;

  // register offsets of the byte map
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h09;
  localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h12;
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'h13;
  localparam logic [7:0] ADDR_SUBTIMER_LIMIT = 8'h14;

  // field positions
  localparam int ROUTE_EN_BIT = 3;
  localparam int PULSE_MODE_BIT = 7;
  localparam int TIMER_ENABLE_BIT = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 4;
  localparam int TICK_HI = 1;
  localparam int TICK_LO = 0;
  // control byte bits that really exist; 3 and 2 read zero
  localparam logic [7:0] CONTROL_MASK = 8'hf3;

  // reset and load values, smallest accepted limits
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] MIN_DOWN_LIMIT = 8'h02;
  localparam logic [7:0] MIN_UP_LIMIT = 8'h01;

  // default sub limits per tick code
  localparam logic [7:0] SUB_DEFAULT_4K = 8'h29;
  localparam logic [7:0] SUB_DEFAULT_100HZ = 8'h64;
  localparam logic [7:0] SUB_DEFAULT_60 = 8'h3c;

  // tick rate codes
  typedef enum logic [1:0] {
    TICK_4KHZ = 2'h0,
    TICK_100HZ = 2'h1,
    TICK_1SEC = 2'h2,
    TICK_1MIN = 2'h3
  } tick_rate_sel_t;

  // timer function codes
  typedef enum logic [1:0] {
    FUNC_COUNT_DOWN = 2'h0,
    FUNC_ALARM_DOWN = 2'h1,
    FUNC_WATCHDOG_UP = 2'h2,
    FUNC_POWER_FAIL_UP = 2'h3
  } timer_function_sel_t;

  // one-cycle tick pulses from the oscillator divider
  typedef struct packed {
    logic sub_4khz;
    logic sub_100hz;
    logic sub_1sec;
    logic sub_1min;
  } tick_t;

  // one byte write from the serial interface
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

/* rtc_timer_counter_unit.sv */
// two-stage timer: sub counter, main counter, expiry flag and interrupt pin
`timescale 1ns/1ps
module rtc_timer_counter_unit
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire rtc_timer_pkg::reg_write_t i_reg_write,
  input wire logic [7:0] i_reg_read_addr,
  output logic [7:0] o_reg_read_data,
  input wire rtc_timer_pkg::tick_t i_tick,
  input wire logic i_alarm_flag_event,
  input wire logic i_battery_mode,
  input wire logic i_flag_clear,
  output logic o_timer_expired_flag,
  output logic o_second_interrupt_pin_n
);

  // effective sub limit from register and tick code
  function automatic logic [7:0] eff_sub_limit(input logic [7:0] lim, input logic [1:0] code);
    logic [7:0] dflt;
    dflt = rtc_timer_pkg::SUB_DEFAULT_60;
    unique case (code)
      rtc_timer_pkg::TICK_4KHZ: dflt = rtc_timer_pkg::SUB_DEFAULT_4K;
      rtc_timer_pkg::TICK_100HZ: dflt = rtc_timer_pkg::SUB_DEFAULT_100HZ;
      rtc_timer_pkg::TICK_1SEC: dflt = rtc_timer_pkg::SUB_DEFAULT_60;
      rtc_timer_pkg::TICK_1MIN: dflt = rtc_timer_pkg::SUB_DEFAULT_60;
    endcase
    return (lim == rtc_timer_pkg::BYTE_ZERO) ? dflt : lim;
  endfunction

  // true when the function counts downward
  function automatic logic is_down(input logic [1:0] func);
    // codes 00 and 01 count down
    return (func == rtc_timer_pkg::FUNC_COUNT_DOWN) || (func == rtc_timer_pkg::FUNC_ALARM_DOWN);
  endfunction

  // counter state machine
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT_ALARM = 5'b00010,
    ST_COUNT = 5'b00100,
    ST_LOW = 5'b01000,
    ST_STOPPED = 5'b10000
  } timer_state_t;

  logic [7:0] interrupt_control; // route enable lives in bit 3
  logic [7:0] timer_control; // pulse, enable, function, tick
  logic [7:0] main_limit; // main counter limit
  logic [7:0] sub_limit; // sub counter limit, write only
  logic [7:0] main_count; // readable main counter
  logic [7:0] sub_count; // hidden sub counter
  logic periodic_active; // latched periodic mode
  logic pin_low; // internal expiry level
  logic enable_prev; // enable bit one cycle ago
  timer_state_t state; // current state
  logic [1:0] func; // decoded function field
  logic [1:0] tick_code; // decoded tick field
  logic timer_enable_bit; // enable bit
  logic pulse_mode_bit; // pulse bit
  logic enable_rise; // enable went 0 to 1
  logic enable_fall; // enable went 1 to 0
  logic limit_bad; // limit too small for the function
  logic sub_tick; // selected sub tick pulse
  logic overflow; // sub counter overflow this cycle
  logic [7:0] sub_eff; // effective sub limit
  logic [7:0] main_load; // main load value on start
  logic [7:0] main_step; // main after one step
  logic expire_now; // main reaches its end on this step
  logic ctrl_write; // write to control byte
  logic [7:0] next_control; // control byte after a write

  // field decode
  always_comb
  begin
    func = timer_control[rtc_timer_pkg::FUNC_HI:rtc_timer_pkg::FUNC_LO];
    tick_code = timer_control[rtc_timer_pkg::TICK_HI:rtc_timer_pkg::TICK_LO];
    timer_enable_bit = timer_control[rtc_timer_pkg::TIMER_ENABLE_BIT];
    pulse_mode_bit = timer_control[rtc_timer_pkg::PULSE_MODE_BIT];
    enable_rise = timer_enable_bit && !enable_prev;
    enable_fall = !timer_enable_bit && enable_prev;
    ctrl_write = i_reg_write.en && (i_reg_write.addr == rtc_timer_pkg::ADDR_TIMER_CONTROL);
    next_control = i_reg_write.data & rtc_timer_pkg::CONTROL_MASK;
  end

  // tick select, overflow and step values
  always_comb
  begin
    sub_tick = 1'b0;
    unique case (tick_code)
      rtc_timer_pkg::TICK_4KHZ: sub_tick = i_tick.sub_4khz;
      rtc_timer_pkg::TICK_100HZ: sub_tick = i_tick.sub_100hz;
      rtc_timer_pkg::TICK_1SEC: sub_tick = i_tick.sub_1sec;
      rtc_timer_pkg::TICK_1MIN: sub_tick = i_tick.sub_1min;
    endcase
    // power fail counts only on battery
    if ((func == rtc_timer_pkg::FUNC_POWER_FAIL_UP) && !i_battery_mode)
    begin
      sub_tick = 1'b0;
    end
    sub_eff = eff_sub_limit(sub_limit, tick_code);
    overflow = sub_tick && (sub_count >= sub_eff);
    // load limit for down, one for up
    main_load = is_down(func) ? main_limit : rtc_timer_pkg::COUNT_ONE;
    main_step = is_down(func) ? main_count - rtc_timer_pkg::COUNT_ONE : main_count + rtc_timer_pkg::COUNT_ONE;
    // expiry at zero down, at limit up
    expire_now = is_down(func) ? (main_step == rtc_timer_pkg::BYTE_ZERO) : (main_step == main_limit);
    limit_bad = is_down(func) ? (main_limit < rtc_timer_pkg::MIN_DOWN_LIMIT)
                              : (main_limit < rtc_timer_pkg::MIN_UP_LIMIT);
  end

  // route and limit registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      interrupt_control <= rtc_timer_pkg::BYTE_ZERO;
      main_limit <= rtc_timer_pkg::BYTE_ZERO;
      sub_limit <= rtc_timer_pkg::BYTE_ZERO;
    end
    else if (i_reg_write.en)
    begin
      // byte writes by offset
      if (i_reg_write.addr == rtc_timer_pkg::ADDR_INTERRUPT_CONTROL)
      begin
        interrupt_control <= i_reg_write.data;
      end
      if (i_reg_write.addr == rtc_timer_pkg::ADDR_TIMER_LIMIT)
      begin
        main_limit <= i_reg_write.data;
      end
      if (i_reg_write.addr == rtc_timer_pkg::ADDR_SUBTIMER_LIMIT)
      begin
        sub_limit <= i_reg_write.data;
      end
    end
  end

  // control byte; a refused start drops the enable bit
  always_ff @(posedge i_ref_clk)
  begin
    // pulse and enable reset to zero
    if (i_srst)
    begin
      timer_control <= rtc_timer_pkg::BYTE_ZERO;
    end
    else if (ctrl_write)
    begin
      timer_control <= next_control;
    end
    // enable with bad limit stays disabled
    else if (enable_rise && limit_bad)
    begin
      timer_control[rtc_timer_pkg::TIMER_ENABLE_BIT] <= 1'b0;
    end
  end

  // enable edge history
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      enable_prev <= 1'b0;
    end
    else
    begin
      enable_prev <= timer_enable_bit && !(enable_rise && limit_bad);
    end
  end

  // periodic mode latch
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      periodic_active <= 1'b0;
    end
    // clearing pulse bit leaves periodic at once
    else if (!pulse_mode_bit)
    begin
      periodic_active <= 1'b0;
    end
    // periodic only taken at the enable edge
    else if (enable_rise)
    begin
      periodic_active <= 1'b1;
    end
  end

  // expiry flag; a set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_timer_expired_flag <= 1'b0;
    end
    else if ((state == ST_COUNT) && overflow && expire_now)
    begin
      o_timer_expired_flag <= 1'b1;
    end
    else if (i_flag_clear)
    begin
      o_timer_expired_flag <= 1'b0;
    end
  end

  // counters, pin level and state
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state <= ST_IDLE;
      main_count <= rtc_timer_pkg::BYTE_ZERO;
      sub_count <= rtc_timer_pkg::COUNT_ONE;
      pin_low <= 1'b0;
    end
    // disable halts and releases the pin
    else if (!timer_enable_bit || enable_fall)
    begin
      state <= ST_IDLE;
      main_count <= rtc_timer_pkg::BYTE_ZERO;
      sub_count <= rtc_timer_pkg::COUNT_ONE;
      pin_low <= 1'b0;
    end
    // alarm function waits for an alarm
    else if (enable_rise && !limit_bad && (func == rtc_timer_pkg::FUNC_ALARM_DOWN))
    begin
      state <= ST_WAIT_ALARM;
    end
    else if (enable_rise && !limit_bad)
    begin
      state <= ST_COUNT;
      main_count <= main_load;
      sub_count <= rtc_timer_pkg::COUNT_ONE;
    end
    // flag clear restarts as a first cycle
    else if (i_flag_clear && o_timer_expired_flag && (state != ST_WAIT_ALARM))
    begin
      // clear releases the pin and restarts
      pin_low <= 1'b0;
      main_count <= main_load;
      sub_count <= rtc_timer_pkg::COUNT_ONE;
      state <= (func == rtc_timer_pkg::FUNC_ALARM_DOWN) ? ST_WAIT_ALARM : ST_COUNT;
    end
    else
    begin
      unique case (state)
        // disabled, nothing moves
        ST_IDLE:
        begin
          state <= ST_IDLE;
        end
        ST_WAIT_ALARM:
        begin
          if (i_alarm_flag_event)
          begin
            state <= ST_COUNT;
            main_count <= main_load;
            sub_count <= rtc_timer_pkg::COUNT_ONE;
          end
        end
        // counting; further alarms ignored here
        ST_COUNT:
        begin
          if (overflow)
          begin
            // step main, sub back to one
            main_count <= main_step;
            sub_count <= rtc_timer_pkg::COUNT_ONE;
            if (expire_now)
            begin
              pin_low <= 1'b1;
              state <= (periodic_active || (func == rtc_timer_pkg::FUNC_WATCHDOG_UP)) ? ST_LOW : ST_STOPPED;
            end
          end
          else if (sub_tick)
          begin
            sub_count <= sub_count + rtc_timer_pkg::COUNT_ONE;
          end
        end
        // periodic low phase lasting one sub period
        ST_LOW:
        begin
          if (overflow)
          begin
            pin_low <= 1'b0;
            sub_count <= rtc_timer_pkg::COUNT_ONE;
            main_count <= is_down(func) ? main_limit - rtc_timer_pkg::COUNT_ONE : rtc_timer_pkg::COUNT_ONE;
            state <= (func == rtc_timer_pkg::FUNC_ALARM_DOWN) ? ST_WAIT_ALARM : ST_COUNT;
          end
          else if (sub_tick)
          begin
            sub_count <= sub_count + rtc_timer_pkg::COUNT_ONE;
          end
          // leaving periodic holds like single mode
          if (!periodic_active && (func != rtc_timer_pkg::FUNC_WATCHDOG_UP))
          begin
            state <= ST_STOPPED;
          end
        end
        // held until the flag is cleared
        ST_STOPPED:
        begin
          state <= ST_STOPPED;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // registered pin, active low
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_second_interrupt_pin_n <= 1'b1;
    end
    else
    begin
      o_second_interrupt_pin_n <= !(pin_low && interrupt_control[rtc_timer_pkg::ROUTE_EN_BIT]);
    end
  end

  // registered read port
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_reg_read_data <= rtc_timer_pkg::BYTE_ZERO;
    end
    else
    begin
      unique case (i_reg_read_addr)
        rtc_timer_pkg::ADDR_INTERRUPT_CONTROL: o_reg_read_data <= interrupt_control;
        rtc_timer_pkg::ADDR_TIMER_CONTROL: o_reg_read_data <= timer_control;
        rtc_timer_pkg::ADDR_TIMER_LIMIT: o_reg_read_data <= main_limit;
        rtc_timer_pkg::ADDR_TIMER_COUNT: o_reg_read_data <= main_count;
        // sub limit is write only and reads zero
        default: o_reg_read_data <= rtc_timer_pkg::BYTE_ZERO;
      endcase
    end
  end

endmodule

/* tick_source.sv */
// divider model: one-cycle tick pulses at four unrelated spacings
`timescale 1ns/1ps
module tick_source
(
  input wire logic i_clk,
  input wire logic i_run,
  output rtc_timer_pkg::tick_t o_tick
);
  int cnt = 0; // cycles since ticks started
  initial o_tick = '0;
  // pulses leave at the falling edge and stand one cycle
  always @(negedge i_clk)
  begin
    cnt <= i_run ? cnt + 1 : 0;
    o_tick.sub_4khz <= i_run && (cnt % 3 == 2);
    o_tick.sub_100hz <= i_run && (cnt % 5 == 4);
    o_tick.sub_1sec <= i_run && (cnt % 7 == 6);
    o_tick.sub_1min <= i_run && (cnt % 11 == 10);
  end
endmodule

/* rtc_timer_checker.sv */
// assertion checker bound to the timer unit
`timescale 1ns/1ps
module rtc_timer_checker
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire rtc_timer_pkg::reg_write_t i_reg_write,
  input wire logic [7:0] i_reg_read_addr,
  input wire logic [7:0] o_reg_read_data,
  input wire rtc_timer_pkg::tick_t i_tick,
  input wire logic i_flag_clear,
  input wire logic o_timer_expired_flag,
  input wire logic o_second_interrupt_pin_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  a_reset_idle: assert property (
    $fell(i_srst) |-> o_second_interrupt_pin_n && !o_timer_expired_flag)
    else $error("pin or flag not idle after reset");
  a_flag_on_tick: assert property (
    $rose(o_timer_expired_flag) |-> $past(|i_tick))
    else $error("flag rose without a tick");
  a_pin_after_flag: assert property (
    $fell(o_second_interrupt_pin_n) |-> $past(o_timer_expired_flag))
    else $error("pin fell without flag");
  a_pin_needs_flag: assert property (
    !o_second_interrupt_pin_n |-> o_timer_expired_flag || $past(i_flag_clear))
    else $error("pin low with flag clear");
  a_flag_sticky: assert property (
    o_timer_expired_flag && !i_flag_clear |=> o_timer_expired_flag)
    else $error("flag cleared by itself");
  a_flag_clear: assert property (
    i_flag_clear && !(|i_tick) |=> !o_timer_expired_flag)
    else $error("flag clear ignored");
  a_pin_release: assert property (
    $rose(o_second_interrupt_pin_n) |-> $past(i_flag_clear, 2) || $past(|i_tick, 2)
      || $past(i_reg_write.en, 2) || $past(i_reg_write.en, 3))
    else $error("pin released without cause");
  a_sub_reads_zero: assert property (
    i_reg_read_addr == rtc_timer_pkg::ADDR_SUBTIMER_LIMIT |=> o_reg_read_data == 8'h00)
    else $error("sub limit read not zero");
  a_ctrl_gap_zero: assert property (
    i_reg_read_addr == rtc_timer_pkg::ADDR_TIMER_CONTROL |=> o_reg_read_data[3:2] == 2'h0)
    else $error("control bits 3:2 not zero");
endmodule

bind rtc_timer_counter_unit rtc_timer_checker chk_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_reg_write(i_reg_write), .i_reg_read_addr(i_reg_read_addr), .o_reg_read_data(o_reg_read_data),
  .i_tick(i_tick), .i_flag_clear(i_flag_clear), .o_timer_expired_flag(o_timer_expired_flag),
  .o_second_interrupt_pin_n(o_second_interrupt_pin_n));

/* tb_top.sv */
// self-checking bench for the rtc timer counter unit
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0; // reference clock
  logic srst = 1'b1; // sync reset
  rtc_timer_pkg::reg_write_t wr = '0; // byte write
  logic [7:0] raddr = 8'h00; // read address
  logic [7:0] rdata; // read data
  rtc_timer_pkg::tick_t tick; // divider ticks
  logic run = 1'b0; // tick gate
  logic alarm = 1'b0; // alarm pulse
  logic batt = 1'b0; // battery mode
  logic fclr = 1'b0; // flag clear pulse
  logic flag; // status flag
  logic pin_n; // interrupt pin
  logic pend = 1'b0; // read issued
  logic look = 1'b0; // read data due
  logic [7:0] exp_q[$]; // expected read bytes
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int k; // ticks counted
  logic [7:0] lim; // random main limit

  initial forever #10 clk = ~clk;

  tick_source src_u (.i_clk(clk), .i_run(run), .o_tick(tick));

  rtc_timer_counter_unit dut_u (.i_ref_clk(clk), .i_srst(srst), .i_reg_write(wr),
    .i_reg_read_addr(raddr), .o_reg_read_data(rdata), .i_tick(tick),
    .i_alarm_flag_event(alarm), .i_battery_mode(batt), .i_flag_clear(fclr),
    .o_timer_expired_flag(flag), .o_second_interrupt_pin_n(pin_n));

  task automatic close_out;
    $display("checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // byte compare
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // pin or flag compare
  task automatic chkb(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // one write pulse
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr <= {1'b1, a, d};
    @(negedge clk);
    wr <= '0;
  endtask

  // read request; expectation queued for the monitor
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    raddr <= a;
    exp_q.push_back(e);
    pend <= 1'b1;
    @(negedge clk);
    pend <= 1'b0;
  endtask

  // host write of zero to the flag
  task automatic clr;
    @(negedge clk);
    fclr <= 1'b1;
    @(negedge clk);
    fclr <= 1'b0;
  endtask

  // stop ticks, disable, clear flag
  task automatic off;
    run <= 1'b0;
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
    clr;
  endtask

  // count selected ticks until flag set, pin high or pin low
  task automatic cnt(input int sel, input int mode);
    k = 0;
    run <= 1'b1;
    repeat (6000)
    begin
      @(negedge clk);
      if (tick[3 - sel] === 1'b1)
        k++;
      if (mode == 0 ? flag === 1'b1 : pin_n === (mode == 1))
        break;
    end
  endtask

  // read data is due one cycle after its address
  always @(posedge clk) look <= pend;
  always @(negedge clk)
    if (look)
      chk8(rdata, exp_q.pop_front());

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      close_out;
    end
  end

  initial
  begin
    void'($urandom(89659));
    // limit kept at two or more
    lim = 8'h02 + 8'($urandom % 4);
    repeat (6) @(negedge clk);
    srst <= 1'b0;
    rreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, 8'h00);
    rreg(rtc_timer_pkg::ADDR_SUBTIMER_LIMIT, 8'h00);
    rreg(8'h30, 8'h00);
    wreg(rtc_timer_pkg::ADDR_INTERRUPT_CONTROL, 8'h08);
    wreg(rtc_timer_pkg::ADDR_TIMER_LIMIT, lim);
    wreg(rtc_timer_pkg::ADDR_SUBTIMER_LIMIT, 8'h03);
    wreg(rtc_timer_pkg::ADDR_TIMER_COUNT, 8'h55);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h40);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, lim);
    cnt(0, 0);
    chk8(k[7:0], lim * 8'h03);
    @(negedge clk);
    chkb(pin_n, 1'b0);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, 8'h00);
    repeat (20) @(negedge clk);
    chkb(pin_n, 1'b0);
    run <= 1'b0;
    clr;
    @(negedge clk);
    chkb(pin_n, 1'b1);
    cnt(0, 0);
    chk8(k[7:0], lim * 8'h03);
    run <= 1'b0;
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, 8'h00);
    chkb(pin_n, 1'b1);
    chkb(flag, 1'b1);
    // enable toggle restarts, flag stays set
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h40);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, lim);
    chkb(flag, 1'b1);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
    clr;
    wreg(rtc_timer_pkg::ADDR_TIMER_LIMIT, 8'h01);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h40);
    @(negedge clk);
    rreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
    // default sub limit, route off
    wreg(rtc_timer_pkg::ADDR_INTERRUPT_CONTROL, 8'h00);
    wreg(rtc_timer_pkg::ADDR_TIMER_LIMIT, 8'h02);
    wreg(rtc_timer_pkg::ADDR_SUBTIMER_LIMIT, 8'h00);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h41);
    cnt(1, 0);
    chk8(k[7:0], 8'hc8);
    @(negedge clk);
    chkb(pin_n, 1'b1);
    off;
    // periodic count-down
    wreg(rtc_timer_pkg::ADDR_INTERRUPT_CONTROL, 8'h08);
    wreg(rtc_timer_pkg::ADDR_TIMER_LIMIT, lim);
    wreg(rtc_timer_pkg::ADDR_SUBTIMER_LIMIT, 8'h02);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h80);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'hc0);
    cnt(0, 0);
    chk8(k[7:0], lim * 8'h02);
    cnt(0, 1);
    chk8(k[7:0], 8'h02);
    cnt(0, 2);
    chk8(k[7:0], (lim - 8'h01) * 8'h02);
    off;
    // pulse bit set while enabled stays single
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h42);
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'hc2);
    cnt(2, 0);
    chk8(k[7:0], lim * 8'h02);
    repeat (40) @(negedge clk);
    chkb(pin_n, 1'b0);
    off;
    // watchdog counts up from one
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h63);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, 8'h01);
    cnt(3, 0);
    chk8(k[7:0], (lim - 8'h01) * 8'h02);
    off;
    // power fail count-up waits for battery
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h73);
    run <= 1'b1;
    repeat (40) @(negedge clk);
    chkb(flag, 1'b0);
    rreg(rtc_timer_pkg::ADDR_TIMER_COUNT, 8'h01);
    batt <= 1'b1;
    cnt(3, 0);
    chk8(k[7:0], (lim - 8'h01) * 8'h02);
    off;
    batt <= 1'b0;
    // alarm-triggered count-down waits for the alarm
    wreg(rtc_timer_pkg::ADDR_TIMER_CONTROL, 8'h50);
    run <= 1'b1;
    repeat (40) @(negedge clk);
    chkb(flag, 1'b0);
    run <= 1'b0;
    @(negedge clk);
    alarm <= 1'b1;
    @(negedge clk);
    alarm <= 1'b0;
    cnt(0, 0);
    chk8(k[7:0], lim * 8'h02);
    off;
    close_out;
  end
endmodule
